// [fbx_exec.sv]
// fbx_exec: executor for flag branches, i/o bit set/clear, shifts, flag ops, bit and register moves
// assumes: a decoder hands one command at a time on cmd_valid/cmd_ready; software uses the plain
// register port (read data one cycle after the read strobe)
//
// How it works
// - branch_if_plus taken when negative flag clear
// - signed ge taken when N xor V zero
// - signed lt taken when N xor V one
// - half-carry set and clear branch pair
// - transfer bit set and clear branch pair
// - overflow set and clear branch pair
// - interrupt enabled and disabled branch pair
// - taken: pc plus offset plus one, flags kept
// - i/o bit set/clear, two cycles, flags kept
// - left shift, zero in, updates Z C N V
// - right shift, zero in, updates Z C N V
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - single flag set or clear, one cycle
// - global interrupt enable set and clear
// - bit copied into transfer flag only
// - transfer flag copied into register bit
// - register and pair copy, one cycle, flags kept
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module fbx_exec
   import fbx_pkg::*;
#(
   parameter int PC_W = PC_W_DEF
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              cmd_valid,
   input  wire fbx_cmd_t          cmd_in,
   output      logic              cmd_ready,
   output      logic              cmd_done,
   output      logic              branch_taken,
   output      logic [PC_W-1:0]   pc,
   output      logic [7:0]        status_flags,
   input  wire fbx_bus_req_t      bus_req,
   output      logic [7:0]        bus_rdata
);

   typedef struct packed {
      fbx_state_t       st;
      fbx_cmd_t         cmd;
      logic [PC_W-1:0]  pc;
      logic [7:0]       status;
      logic             ready;
      logic             done;
      logic             taken;
   } fbx_exec_state_t;

   fbx_exec_state_t q;
   fbx_exec_state_t next_q;

   logic [2:0][MEM_AW-1:0]  rd_addr;
   logic [2:0][7:0]         rd_data;
   logic [2:0]              wr_en;
   logic [2:0][MEM_AW-1:0]  wr_addr;
   logic [2:0][7:0]         wr_data;
   logic                    alt_sel;
   logic [7:0]              alt_data;
   logic                    accept;
   logic                    br_cond;
   logic                    is_branch;
   logic [PC_W-1:0]         offset_ext;
   logic [7:0]              opa;
   logic [7:0]              opb;
   logic [7:0]              res;
   logic                    res_c;

   assign accept = cmd_valid && q.ready;

   // operand fetch addresses follow the command on the accepting edge
   always_comb begin
      rd_addr[0] = {1'b0, cmd_in.rd};
      rd_addr[1] = {1'b0, cmd_in.rr};
      if (cmd_in.op == OP_IO_BIT_SET || cmd_in.op == OP_IO_BIT_CLR) begin
         rd_addr[0] = {MEM_IO_SPACE, cmd_in.rd};
      end else if (cmd_in.op == OP_PAIR_COPY) begin
         rd_addr[0] = {1'b0, cmd_in.rr[4:1], 1'b1};
         rd_addr[1] = {1'b0, cmd_in.rr[4:1], 1'b0};
      end
      rd_addr[2] = bus_req.addr[MEM_AW-1:0];
   end

   // non-memory read answers ride through the last read port register
   always_comb begin
      alt_sel  = bus_req.addr[MEM_AW];
      alt_data = 8'h00;
      unique case (bus_req.addr)
         ADDR_STATUS: alt_data = q.status;
         ADDR_PC_LO:  alt_data = 8'(q.pc);
         ADDR_PC_HI:  alt_data = 8'(q.pc >> 8);
         ADDR_EXEC:   alt_data = {6'h00, q.st};
         default:     alt_data = 8'h00;
      endcase
   end

   fbx_regmem #(
      .W     (DATA_W),
      .DEPTH (MEM_DEPTH),
      .AW    (MEM_AW),
      .NR    (3),
      .NW    (3)
   ) u_mem (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data),
      .alt_sel  (alt_sel),
      .alt_data (alt_data),
      .wr_en    (wr_en),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data)
   );

   // branch condition from the held command and current flags
   always_comb begin
      br_cond   = 1'b0;
      is_branch = 1'b1;
      unique case (q.cmd.op)
         OP_BR_FLAG_SET:  br_cond = q.status[q.cmd.sel];
         OP_BR_FLAG_CLR:  br_cond = !q.status[q.cmd.sel];
         OP_BR_SIGNED_GE: br_cond = (q.status[FLAG_N] ^ q.status[FLAG_V]) == 1'b0;
         OP_BR_SIGNED_LT: br_cond = (q.status[FLAG_N] ^ q.status[FLAG_V]) == 1'b1;
         default:         is_branch = 1'b0;
      endcase
   end

   assign offset_ext = {{(PC_W - 7){q.cmd.offset[6]}}, q.cmd.offset};
   assign opa        = rd_data[0];
   assign opb        = rd_data[1];

   // shift and rotate results with outgoing carry
   always_comb begin
      res   = opa;
      res_c = q.status[FLAG_C];
      unique case (q.cmd.op)
         OP_SHIFT_LEFT:   begin res = {opa[6:0], 1'b0};             res_c = opa[7]; end
         OP_SHIFT_RIGHT:  begin res = {1'b0, opa[7:1]};             res_c = opa[0]; end
         OP_ROTATE_LEFT:  begin res = {opa[6:0], q.status[FLAG_C]}; res_c = opa[7]; end
         OP_ROTATE_RIGHT: begin res = {q.status[FLAG_C], opa[7:1]}; res_c = opa[0]; end
         default:         res = opa;
      endcase
   end

   // sequencing, execution and register port writes
   always_comb begin
      next_q       = q;
      next_q.done  = 1'b0;
      next_q.taken = 1'b0;
      wr_en        = 3'b000;
      wr_addr[0]   = {1'b0, q.cmd.rd};
      wr_addr[1]   = {1'b0, q.cmd.rd[4:1], 1'b1};
      wr_addr[2]   = bus_req.addr[MEM_AW-1:0];
      wr_data[0]   = res;
      wr_data[1]   = opa;
      wr_data[2]   = bus_req.wdata;
      // software writes to the store land in any state; exec port wins on a clash
      wr_en[2]     = bus_req.wr && !bus_req.addr[MEM_AW];
      unique case (q.st)
         ST_IDLE: begin
            if (accept) begin
               next_q.cmd   = cmd_in;
               next_q.st    = ST_EXEC;
               next_q.ready = 1'b0;
            end else if (bus_req.wr) begin
               // software owns status and pc only while nothing executes
               unique case (bus_req.addr)
                  ADDR_STATUS: next_q.status = bus_req.wdata;
                  ADDR_PC_LO:  next_q.pc     = (q.pc & ~PC_W'(8'hFF)) | PC_W'(bus_req.wdata);
                  ADDR_PC_HI:  next_q.pc     = PC_W'({bus_req.wdata, q.pc[7:0]});
                  default:     next_q.pc     = q.pc;
               endcase
            end
         end
         ST_EXEC: begin
            next_q.st    = ST_IDLE;
            next_q.ready = 1'b1;
            next_q.done  = 1'b1;
            next_q.pc    = q.pc + PC_W'(1);
            if (is_branch && br_cond) begin
               next_q.pc    = q.pc + offset_ext + PC_W'(1);
               next_q.taken = 1'b1;
               next_q.st    = ST_EXTRA;
               next_q.ready = 1'b0;
               next_q.done  = 1'b0;
            end
            unique case (q.cmd.op)
               OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
                  wr_en[0]        = 1'b1;
                  wr_addr[0]      = {MEM_IO_SPACE, q.cmd.rd};
                  wr_data[0]      = opa;
                  wr_data[0][q.cmd.sel] = (q.cmd.op == OP_IO_BIT_SET);
                  next_q.st       = ST_EXTRA;
                  next_q.ready    = 1'b0;
                  next_q.done     = 1'b0;
               end
               OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
                  wr_en[0]               = 1'b1;
                  next_q.status[FLAG_C]  = res_c;
                  next_q.status[FLAG_Z]  = (res == 8'h00);
                  next_q.status[FLAG_N]  = res[7];
                  next_q.status[FLAG_V]  = res[7] ^ res_c;
               end
               OP_NIBBLE_SWAP: begin
                  wr_en[0]   = 1'b1;
                  wr_data[0] = {opa[3:0], opa[7:4]};
               end
               OP_FLAG_SET: next_q.status[q.cmd.sel] = 1'b1;
               OP_FLAG_CLR: next_q.status[q.cmd.sel] = 1'b0;
               OP_BIT_TO_TFLAG: next_q.status[FLAG_T] = opa[q.cmd.sel];
               OP_TFLAG_TO_BIT: begin
                  wr_en[0]              = 1'b1;
                  wr_data[0]            = opa;
                  wr_data[0][q.cmd.sel] = q.status[FLAG_T];
               end
               OP_REG_COPY: begin
                  wr_en[0]   = 1'b1;
                  wr_data[0] = opb;
               end
               OP_PAIR_COPY: begin
                  wr_en[1:0] = 2'b11;
                  wr_addr[0] = {1'b0, q.cmd.rd[4:1], 1'b0};
                  wr_data[0] = opb;
               end
               default: next_q.status = q.status;
            endcase
         end
         ST_EXTRA: begin
            // second cycle of a taken branch or an i/o bit write
            next_q.st    = ST_IDLE;
            next_q.ready = 1'b1;
            next_q.done  = 1'b1;
            if (q.cmd.op == OP_IO_BIT_SET || q.cmd.op == OP_IO_BIT_CLR) begin
               next_q.pc = q.pc + PC_W'(1);
            end
         end
         default: begin
            next_q.st    = ST_IDLE;
            next_q.ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q        <= '0;
         q.status <= STATUS_RST;
         q.ready  <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from the state register; bus_rdata from the store's last read port register
   assign cmd_ready    = q.ready;
   assign cmd_done     = q.done;
   assign branch_taken = q.taken;
   assign pc           = q.pc;
   assign status_flags = q.status;
   assign bus_rdata    = rd_data[2];

   // checks on executed behaviour
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_plus_taken: assert property (
      accept && cmd_in.op == OP_BR_FLAG_CLR && cmd_in.sel == FLAG_N
      |-> ##2 branch_taken == !$past(status_flags[FLAG_N], 2))
      else $error("plus branch decision wrong");

   a_signed_ge: assert property (
      accept && cmd_in.op == OP_BR_SIGNED_GE
      |-> ##2 branch_taken == ($past(status_flags[FLAG_N] ^ status_flags[FLAG_V], 2) == 1'b0))
      else $error("signed ge decision wrong");

   a_signed_lt: assert property (
      accept && cmd_in.op == OP_BR_SIGNED_LT
      |-> ##2 branch_taken == ($past(status_flags[FLAG_N] ^ status_flags[FLAG_V], 2) == 1'b1))
      else $error("signed lt decision wrong");

   a_flag_branch: assert property (
      q.st == ST_EXEC && q.cmd.op == OP_BR_FLAG_SET
      |=> branch_taken == $past(status_flags[q.cmd.sel]))
      else $error("flag set branch decision wrong");

   a_taken_target: assert property (
      branch_taken |-> pc == $past(pc) + $past(offset_ext) + PC_W'(1) && status_flags == $past(status_flags))
      else $error("taken branch target or flags wrong");

   a_branch_timing: assert property (
      accept && cmd_in.op inside {OP_BR_FLAG_SET, OP_BR_FLAG_CLR, OP_BR_SIGNED_GE, OP_BR_SIGNED_LT}
      |-> ##1 !cmd_ready ##1 ((branch_taken && !cmd_ready ##1 cmd_done) or (!branch_taken && cmd_done)))
      else $error("branch cycle count wrong");

   a_io_two_cycle: assert property (
      accept && cmd_in.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLR}
      |-> ##1 !cmd_ready [*2] ##1 (cmd_done && status_flags == $past(status_flags, 3)))
      else $error("io bit op timing or flags wrong");

   a_shift_flags: assert property (
      q.st == ST_EXEC && q.cmd.op inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT}
      |=> cmd_done && status_flags[FLAG_Z] == ($past(wr_data[0]) == 8'h00)
          && status_flags[FLAG_V] == (status_flags[FLAG_N] ^ status_flags[FLAG_C]))
      else $error("shift flags wrong");

   a_flag_set_only: assert property (
      q.st == ST_EXEC && q.cmd.op == OP_FLAG_SET
      |=> status_flags == ($past(status_flags) | (8'h01 << $past(q.cmd.sel))))
      else $error("flag set touched other flags");

   a_tflag_store: assert property (
      q.st == ST_EXEC && q.cmd.op == OP_BIT_TO_TFLAG
      |=> status_flags[FLAG_T] == $past(opa[q.cmd.sel])
          && (status_flags & 8'hBF) == ($past(status_flags) & 8'hBF))
      else $error("bit to tflag wrong");

   a_plain_one_cycle: assert property (
      accept && cmd_in.op inside {OP_TFLAG_TO_BIT, OP_REG_COPY, OP_PAIR_COPY, OP_NIBBLE_SWAP}
      |-> ##1 !cmd_ready ##1 (cmd_ready && cmd_done && status_flags == $past(status_flags, 2)))
      else $error("move or swap timing or flags wrong");

endmodule

// [fbx_exec_tb_top.sv]
// fbx_exec_tb_top: self-checking bench for the flag, branch and bit-operation executor
// assumes: fbx_pkg compiled first; bench drives commands and the register port itself
`timescale 1ns/1ps
module fbx_exec_tb_top
   import fbx_pkg::*;
;
   localparam int PW = 12;

   logic              clk_sys;
   logic              rst_n;
   logic              cmd_valid;
   fbx_cmd_t          cmd_in;
   logic              cmd_ready;
   logic              cmd_done;
   logic              branch_taken;
   logic [PW-1:0]     pc;
   logic [7:0]        status_flags;
   fbx_bus_req_t      bus_req;
   logic [7:0]        bus_rdata;
   int                n_errors;
   int                check_count;

   // branch kinds under test, paired with the flag each one looks at
   fbx_op_t           bop [11] = '{OP_BR_FLAG_CLR, OP_BR_SIGNED_GE, OP_BR_SIGNED_LT, OP_BR_FLAG_SET,
                                   OP_BR_FLAG_CLR, OP_BR_FLAG_SET, OP_BR_FLAG_CLR, OP_BR_FLAG_SET,
                                   OP_BR_FLAG_CLR, OP_BR_FLAG_SET, OP_BR_FLAG_CLR};
   logic [2:0]        bsel [11] = '{FLAG_N, FLAG_N, FLAG_N, FLAG_H, FLAG_H, FLAG_T, FLAG_T,
                                   FLAG_V, FLAG_V, FLAG_I, FLAG_I};
   logic [7:0]        stv [4] = '{8'h00, 8'hFF, 8'h04, 8'h08};
   fbx_op_t           sop [4] = '{OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT};
   logic [7:0]        sval [4] = '{8'h81, 8'h40, 8'h01, 8'h00};

   fbx_exec #(.PC_W(PW)) uut (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .cmd_valid    (cmd_valid),
      .cmd_in       (cmd_in),
      .cmd_ready    (cmd_ready),
      .cmd_done     (cmd_done),
      .branch_taken (branch_taken),
      .pc           (pc),
      .status_flags (status_flags),
      .bus_req      (bus_req),
      .bus_rdata    (bus_rdata)
   );

   // 250 MHz core clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard, far beyond the thousand or so cycles the tests need
   initial begin
      #200000;
      n_errors++;
      finish_test();
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_pc(input logic [PW-1:0] got, input logic [PW-1:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_cyc(input int got, input int exp, input string m);
      check_count++;
      if (got != exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s cycles %0d exp %0d", $time, m, got, exp);
      end
   endtask

   // one-cycle write strobe on the register port
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask

   // read strobe; data sampled in the single cycle after it
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      bus_req <= '0;
      #1 d = bus_rdata;
   endtask

   // offer one command, count cycles from the taking edge to cmd_done
   task automatic exec(input fbx_op_t op, input logic [4:0] d, input logic [4:0] r,
                       input logic [2:0] s, input logic [6:0] off, output int cyc, output logic tk);
      tk  = 1'b0;
      cyc = 0;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_in    <= '{op: op, rd: d, rr: r, sel: s, offset: off};
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      for (int n = 1; n <= 8 && cyc == 0; n++) begin
         @(posedge clk_sys);
         #1;
         if (branch_taken === 1'b1) tk = 1'b1;
         if (cmd_done === 1'b1) cyc = n;
      end
   endtask

   function automatic logic br_cond(fbx_op_t op, logic [2:0] s, logic [7:0] st);
      case (op)
         OP_BR_FLAG_SET:  return st[s];
         OP_BR_FLAG_CLR:  return ~st[s];
         OP_BR_SIGNED_GE: return ~(st[FLAG_N] ^ st[FLAG_V]);
         default:         return st[FLAG_N] ^ st[FLAG_V];
      endcase
   endfunction

   // expected {result, status} of a shift or rotate
   function automatic logic [15:0] sh_exp(fbx_op_t op, logic [7:0] a, logic [7:0] st);
      logic [7:0] r;
      logic       c;
      case (op)
         OP_SHIFT_LEFT:  {c, r} = {a, 1'b0};
         OP_SHIFT_RIGHT: {r, c} = {1'b0, a};
         OP_ROTATE_LEFT: {c, r} = {a, st[FLAG_C]};
         default:        {r, c} = {st[FLAG_C], a};
      endcase
      st[FLAG_C] = c;
      st[FLAG_Z] = (r == 8'h00);
      st[FLAG_N] = r[7];
      st[FLAG_V] = r[7] ^ c;
      return {r, st};
   endfunction

   // main sequence
   initial begin
      int          cyc;
      logic        tk;
      logic        cnd;
      logic [7:0]  d;
      logic [7:0]  st;
      logic [6:0]  off;
      logic [15:0] e;
      logic [PW-1:0] pe;
      n_errors = 0;
      check_count = 0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_in = '0;
      bus_req = '0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk8(status_flags, STATUS_RST, "status after reset");
      chk_pc(pc, '0, "pc after reset");
      rd(ADDR_EXEC, d);
      chk8(d, 8'h00, "exec state idle");
      // unmapped place reads zero and ignores writes
      wr(7'h50, 8'hFF);
      rd(7'h50, d);
      chk8(d, 8'h00, "unmapped read");
      // every branch kind against several flag patterns, both offset signs
      for (int i = 0; i < 11; i++) begin
         for (int j = 0; j < 4; j++) begin
            off = j[0] ? 7'h40 : 7'h3F;
            wr(ADDR_STATUS, stv[j]);
            wr(ADDR_PC_LO, 8'h10);
            wr(ADDR_PC_HI, 8'h00);
            cnd = br_cond(bop[i], bsel[i], stv[j]);
            pe = cnd ? PW'(12'h011 + {{5{off[6]}}, off}) : PW'(12'h011);
            exec(bop[i], 5'h00, 5'h00, bsel[i], off, cyc, tk);
            chk_pc(pc, pe, "branch target");
            chk_cyc(cyc, cnd ? 2 : 1, "branch length");
            chk8({7'h00, tk}, {7'h00, cnd}, "branch pulse");
            chk8(status_flags, stv[j], "branch flags");
         end
      end
      // last branch target read back over the register port
      rd(ADDR_PC_LO, d);
      chk8(d, pe[7:0], "pc low read back");
      rd(ADDR_PC_HI, d);
      chk8(d, {4'h0, pe[11:8]}, "pc high read back");
      // i/o bit set and clear
      wr(7'h25, 8'h5A);
      wr(ADDR_STATUS, 8'hC3);
      exec(OP_IO_BIT_SET, 5'h05, 5'h00, 3'h0, 7'h00, cyc, tk);
      chk_cyc(cyc, 2, "io set length");
      exec(OP_IO_BIT_CLR, 5'h05, 5'h00, 3'h6, 7'h00, cyc, tk);
      chk_cyc(cyc, 2, "io clear length");
      rd(7'h25, d);
      chk8(d, 8'h1B, "io bits");
      chk8(status_flags, 8'hC3, "io flags");
      // shifts and rotates over edge operands, carry in low and high
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 8; j++) begin
            st = j[2] ? 8'h31 : 8'h00;
            wr(7'h07, sval[j[1:0]]);
            wr(ADDR_STATUS, st);
            e = sh_exp(sop[i], sval[j[1:0]], st);
            exec(sop[i], 5'h07, 5'h00, 3'h0, 7'h00, cyc, tk);
            chk_cyc(cyc, 1, "shift length");
            chk8(status_flags, e[7:0], "shift flags");
            rd(7'h07, d);
            chk8(d, e[15:8], "shift result");
         end
      end
      // set and clear of each flag alone, interrupt enable included
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_STATUS, 8'h00);
         exec(OP_FLAG_SET, 5'h00, 5'h00, 3'(s), 7'h00, cyc, tk);
         chk8(status_flags, 8'h01 << s, "flag set");
         chk_cyc(cyc, 1, "flag set length");
         wr(ADDR_STATUS, 8'hFF);
         exec(OP_FLAG_CLR, 5'h00, 5'h00, 3'(s), 7'h00, cyc, tk);
         chk8(status_flags, ~(8'h01 << s), "flag clear");
      end
      // bit to transfer flag and back
      wr(7'h0C, 8'h20);
      wr(ADDR_STATUS, 8'h00);
      exec(OP_BIT_TO_TFLAG, 5'h0C, 5'h00, 3'h5, 7'h00, cyc, tk);
      chk8(status_flags, 8'h40, "tflag from one");
      chk_cyc(cyc, 1, "tflag length");
      wr(ADDR_STATUS, 8'hFF);
      exec(OP_BIT_TO_TFLAG, 5'h0C, 5'h00, 3'h4, 7'h00, cyc, tk);
      chk8(status_flags, 8'hBF, "tflag from zero");
      wr(7'h0D, 8'h81);
      wr(ADDR_STATUS, 8'h40);
      exec(OP_TFLAG_TO_BIT, 5'h0D, 5'h00, 3'h3, 7'h00, cyc, tk);
      chk_cyc(cyc, 1, "bit load length");
      wr(ADDR_STATUS, 8'hBF);
      exec(OP_TFLAG_TO_BIT, 5'h0D, 5'h00, 3'h0, 7'h00, cyc, tk);
      rd(7'h0D, d);
      chk8(d, 8'h88, "bit load");
      chk8(status_flags, 8'hBF, "bit load flags");
      // register, pair copy and nibble swap, flags kept
      wr(7'h09, 8'hA5);
      wr(7'h0A, 8'h12);
      wr(7'h0B, 8'h34);
      wr(ADDR_STATUS, 8'h5A);
      exec(OP_REG_COPY, 5'h03, 5'h09, 3'h0, 7'h00, cyc, tk);
      chk_cyc(cyc, 1, "copy length");
      exec(OP_PAIR_COPY, 5'h04, 5'h0A, 3'h0, 7'h00, cyc, tk);
      chk_cyc(cyc, 1, "pair length");
      exec(OP_NIBBLE_SWAP, 5'h03, 5'h00, 3'h0, 7'h00, cyc, tk);
      chk_cyc(cyc, 1, "swap length");
      rd(7'h03, d);
      chk8(d, 8'h5A, "copy then swap");
      rd(7'h04, d);
      chk8(d, 8'h12, "pair low");
      rd(7'h05, d);
      chk8(d, 8'h34, "pair high");
      rd(7'h09, d);
      chk8(d, 8'hA5, "copy source kept");
      chk8(status_flags, 8'h5A, "move flags");
      rd(ADDR_STATUS, d);
      chk8(d, 8'h5A, "move flags read back");
      finish_test();
   end
endmodule

// [fbx_pkg.sv]
// fbx_pkg: shared types and constants of the flag, branch and bit-operation executor
// assumes: single clock clk_sys, synchronous active-low reset, plain register port
package fbx_pkg;

   // memory map of the executor's byte store: 32 working registers, then 32 i/o registers
   localparam int          MEM_AW       = 6;
   localparam int          MEM_DEPTH    = 64;
   localparam int          DATA_W       = 8;
   localparam logic        MEM_IO_SPACE = 1'b1;

   // register port map
   localparam int          BUS_AW       = 7;
   localparam logic [6:0]  ADDR_STATUS  = 7'h40;
   localparam logic [6:0]  ADDR_PC_LO   = 7'h41;
   localparam logic [6:0]  ADDR_PC_HI   = 7'h42;
   localparam logic [6:0]  ADDR_EXEC    = 7'h43;

   // bit positions inside status_flags_register
   localparam logic [2:0]  FLAG_C       = 3'h0;
   localparam logic [2:0]  FLAG_Z       = 3'h1;
   localparam logic [2:0]  FLAG_N       = 3'h2;
   localparam logic [2:0]  FLAG_V       = 3'h3;
   localparam logic [2:0]  FLAG_S       = 3'h4;
   localparam logic [2:0]  FLAG_H       = 3'h5;
   localparam logic [2:0]  FLAG_T       = 3'h6;
   localparam logic [2:0]  FLAG_I       = 3'h7;

   // reset values
   localparam logic [7:0]  STATUS_RST   = 8'h00;
   localparam int          PC_W_DEF     = 12;

   // operations; flag-indexed forms cover every single-flag branch, set and clear
   typedef enum logic [4:0] {
      OP_NOP          = 5'h00,
      OP_BR_FLAG_SET  = 5'h01,  // branch_half_carry_set, branch_tbit_set, branch_overflow_set, branch_irq_enabled
      OP_BR_FLAG_CLR  = 5'h02,  // branch_if_plus and the other clear-tests
      OP_BR_SIGNED_GE = 5'h03,  // branch_signed_ge
      OP_BR_SIGNED_LT = 5'h04,  // branch_signed_lt
      OP_IO_BIT_SET   = 5'h05,  // io_bit_set
      OP_IO_BIT_CLR   = 5'h06,  // io_bit_clear
      OP_SHIFT_LEFT   = 5'h07,  // shift_left_logical
      OP_SHIFT_RIGHT  = 5'h08,  // shift_right_logical
      OP_ROTATE_LEFT  = 5'h09,  // rotate_left_carry
      OP_ROTATE_RIGHT = 5'h0A,  // rotate_right_carry
      OP_NIBBLE_SWAP  = 5'h0B,
      OP_FLAG_SET     = 5'h0C,  // includes global_irq_on
      OP_FLAG_CLR     = 5'h0D,  // includes global_irq_off
      OP_BIT_TO_TFLAG = 5'h0E,  // bit_to_tflag
      OP_TFLAG_TO_BIT = 5'h0F,  // tflag_to_bit
      OP_REG_COPY     = 5'h10,  // reg_copy
      OP_PAIR_COPY    = 5'h11   // reg_pair_copy
   } fbx_op_t;

   // one command: rd is the register or i/o index, sel the flag or bit index
   typedef struct packed {
      fbx_op_t     op;
      logic [4:0]  rd;
      logic [4:0]  rr;
      logic [2:0]  sel;
      logic [6:0]  offset;
   } fbx_cmd_t;

   // register port request
   typedef struct packed {
      logic               wr;
      logic               rd;
      logic [BUS_AW-1:0]  addr;
      logic [7:0]         wdata;
   } fbx_bus_req_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_EXTRA = 2'b10
   } fbx_state_t;

endpackage

// [fbx_regmem.sv]
// fbx_regmem: byte store with registered read ports and prioritised write ports
// assumes: one clock, synchronous reset; the last read port may be overridden by alt data
`timescale 1ns/1ps
module fbx_regmem
   import fbx_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = 64,
   parameter int AW    = 6,
   parameter int NR    = 3,
   parameter int NW    = 3
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire logic [NR-1:0][AW-1:0]   rd_addr,
   output      logic [NR-1:0][W-1:0]    rd_data,
   input  wire logic                    alt_sel,
   input  wire logic [W-1:0]            alt_data,
   input  wire logic [NW-1:0]           wr_en,
   input  wire logic [NW-1:0][AW-1:0]   wr_addr,
   input  wire logic [NW-1:0][W-1:0]    wr_data
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0]  mem;
      logic [NR-1:0][W-1:0]     rdq;
   } fbx_mem_state_t;

   fbx_mem_state_t q;
   fbx_mem_state_t next_q;

   // reads see the old contents; lower write port wins on a shared address
   always_comb begin
      next_q = q;
      for (int i = 0; i < NR; i++) begin
         next_q.rdq[i] = q.mem[rd_addr[i]];
      end
      if (alt_sel) begin
         next_q.rdq[NR-1] = alt_data;
      end
      for (int j = NW - 1; j >= 0; j--) begin
         if (wr_en[j]) begin
            next_q.mem[wr_addr[j]] = wr_data[j];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign rd_data = q.rdq;

endmodule
